// >>> ssr_pkg.sv
/*
 * ssr_pkg: constants shared by the sensor status register bank.
 * Assumes a single 125 MHz system clock and a register port that sees
 * one decoded register request at a time from the Modbus framing logic.
 */
package ssr_pkg;

  // register offsets, as register numbers on the Modbus side
  localparam logic [15:0] ADDR_FAULT      = 16'h0005;
  localparam logic [15:0] ADDR_FW_LOW     = 16'h001B;
  localparam logic [15:0] ADDR_BATT_PCT   = 16'h2007;
  localparam logic [15:0] ADDR_BATT_MIN   = 16'h2008;
  localparam logic [15:0] ADDR_FW_HIGH    = 16'h2009;
  localparam logic [15:0] ADDR_SLEEP      = 16'h200A;
  localparam logic [15:0] ADDR_CONTROL    = 16'h200B;
  localparam logic [15:0] ADDR_STATUS     = 16'h200C;
  localparam logic [15:0] ADDR_FAILS      = 16'h200E;
  localparam logic [15:0] ADDR_UP_SEC_HI  = 16'h2010;
  localparam logic [15:0] ADDR_UP_SEC_LO  = 16'h2011;
  localparam logic [15:0] ADDR_UP_MS      = 16'h2012;

  // fault word bit positions
  localparam int unsigned FB_CALIB     = 14;
  localparam int unsigned FB_ZERO      = 12;
  localparam int unsigned FB_RANGE     = 11;
  localparam int unsigned FB_CLEARING  = 9;
  localparam int unsigned FB_SENSOR    = 7;
  localparam int unsigned FB_PROCESSOR = 6;
  localparam int unsigned FB_MEMORY    = 5;
  localparam int unsigned FB_TEMP      = 2;
  localparam int unsigned FB_SPAN      = 1;
  localparam int unsigned FB_GLOBAL    = 0;

  // control register bits
  localparam int unsigned CB_EXC_EN     = 11;
  localparam int unsigned CB_RST_RADIO  = 7;
  localparam int unsigned CB_RST_MCU    = 6;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_MASK  = 16'h08C0;

  // transceiver status bits; bits 6 and 2 are fixed ones
  localparam int unsigned SB_BATT_FAULT = 5;
  localparam int unsigned SB_BATT_DET   = 4;
  localparam logic [15:0] STATUS_FIXED  = 16'h0044;

  // battery figures
  localparam logic [15:0] BATT_FAIL_STEP = 16'h0004;
  localparam logic [15:0] BATT_FAIL_MAX  = 16'hFFFF;
  localparam logic [15:0] BATT_PCT_MAX   = 16'h0064;
  localparam logic [15:0] BATT_MIN_MAX   = 16'hFFFF;
  localparam logic [15:0] SLEEP_RESET    = 16'h0000;

  // Modbus function and exception codes
  localparam logic [7:0] FUNC_READ       = 8'h03;
  localparam logic [7:0] FUNC_WRITE_ONE  = 8'h06;
  localparam logic [7:0] FUNC_WRITE_MANY = 8'h10;
  localparam logic [7:0] EXC_NONE        = 8'h00;
  localparam logic [7:0] EXC_BAD_FUNC    = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDR    = 8'h02;

  // timebase
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned MS_PERIOD_NS   = 1000000;
  localparam int unsigned MS_TICK_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [15:0] MS_LAST        = 16'h03E7;

  // firmware version defaults; values are arbitrary
  localparam logic [7:0] FW_MAJOR_DEFAULT = 8'h01;
  localparam logic [7:0] FW_MINOR_DEFAULT = 8'h00;

endpackage

// >>> ssr_time_if.sv
/*
 * ssr_time_if: timebase signals from the uptime timer to the bank.
 * Assumes both ends sit on the same system clock.
 */
`timescale 1ns/100ps
interface ssr_time_if;
  logic        clear;
  logic        sec_tick;
  logic [15:0] ms_count;
  logic [31:0] sec_count;

  modport timer (
    input  clear,
    output sec_tick,
    output ms_count,
    output sec_count
  );

  modport user (
    output clear,
    input  sec_tick,
    input  ms_count,
    input  sec_count
  );
endinterface

// >>> ssr_uptime.sv
/*
 * ssr_uptime: millisecond prescaler, millisecond and seconds counters.
 * Assumes clear is a registered one-cycle pulse from the register bank.
 */
`timescale 1ns/100ps
module ssr_uptime
  import ssr_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MS_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  ssr_time_if.timer tm
);
  localparam int unsigned PW = $clog2(TICK_CYCLES);
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

  logic [PW-1:0] pre;
  logic          ms_hit;
  logic          sec_hit;

  assign ms_hit  = (pre == PRE_LAST);
  assign sec_hit = ms_hit && (tm.ms_count == MS_LAST);

  always_ff @(posedge clk) begin
    if (sys_rst || tm.clear) begin
      pre          <= '0;
      tm.sec_tick  <= 1'b0;
      tm.ms_count  <= '0;
      tm.sec_count <= '0;
    end else begin
      pre          <= ms_hit ? '0 : pre + 1'b1;
      tm.sec_tick  <= sec_hit;
      if (ms_hit) begin
        tm.ms_count <= sec_hit ? '0 : tm.ms_count + 16'h0001;
      end
      if (sec_hit) begin
        tm.sec_count <= tm.sec_count + 32'h0000_0001;
      end
    end
  end
endmodule

// >>> ssr_bank.sv
/*
 * ssr_bank: status and control register bank of a wireless gas sensor
 * node, answering decoded Modbus register requests one at a time.
 * Assumes the framing logic splits multi-register writes into single
 * requests and that all inputs are synchronous to clk.
 */
// Summary of operation
// - fault word high byte: calibration 14, zero 12, range 11, clearing 9
// - fault word low byte: sensor 7, processor 6, memory 5, temp 2, span 1
// - each fault bit follows its live condition, one means true
// - battery detected resets to zero, sets on first good poll
// - battery fault resets zero, per poll equals detected and poll failed
// - each failed battery poll adds four to the failure counter
// - writing zero to the failure counter clears it; with a failed poll in the same cycle it becomes four
// - life as percent up to 100 and minutes saturating at 65535
// - firmware word holds major revision high, minor revision low
// - countdown is zero after reset and the radio stays active
// - nonzero countdown decrements each second, radio wakes at zero
// - only the radio sleeps; register port stays live; any 16-bit value
// - control resets zero; bit 11 exceptions, bit 7 full, bit 6 mcu reset
// - status bit 5 battery fault, bit 4 detected, bits 6 and 2 read one
// - two words form a 32-bit seconds count, cleared at any reset
// - millisecond count runs 0 to 999 and wraps, cleared at any reset
// - upper seconds half at the lower address, lower half at the next
// - writes to read-only registers answer normally and change nothing
// - reads use function 03, writes use function 06 or 16
`timescale 1ns/100ps
module ssr_bank
  import ssr_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MS_TICK_CYCLES,
  parameter logic [7:0]  FW_MAJOR    = FW_MAJOR_DEFAULT,
  parameter logic [7:0]  FW_MINOR    = FW_MINOR_DEFAULT
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // register request from the Modbus framing logic
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_func,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_wdata,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  output logic             rsp_exception,
  output logic [7:0]       rsp_exc_code,
  // live sensor fault conditions
  input  wire logic        calib_mode,
  input  wire logic        zero_fault,
  input  wire logic        range_fault,
  input  wire logic        clearing_fault,
  input  wire logic        sensor_fault,
  input  wire logic        processor_fault,
  input  wire logic        memory_fault,
  input  wire logic        temp_fault,
  input  wire logic        span_fault,
  input  wire logic        global_fault,
  // battery poll results
  input  wire logic        batt_poll_done,
  input  wire logic        batt_poll_ok,
  input  wire logic [15:0] batt_pct_in,
  input  wire logic [31:0] batt_min_in,
  // effects on the rest of the node
  output logic             radio_low_power,
  output logic             mcu_reset_pulse,
  output logic             radio_reset_pulse
);

  ssr_time_if tm ();

  ssr_uptime #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_uptime (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tm      (tm)
  );

  logic [15:0] fault_word;
  logic [15:0] control;
  logic [15:0] sleep_count;
  logic [15:0] fail_count;
  logic [15:0] batt_pct;
  logic [15:0] batt_min;
  logic        batt_detect;
  logic        batt_fault;
  logic        soft_rst;

  logic        func_read;
  logic        func_write;
  logic        func_ok;
  logic        addr_ok;
  logic        do_write;
  logic        exc_en;
  logic        give_exc;
  logic        wr_sleep;
  logic        wr_control;
  logic        wr_fails;
  logic        fail_hit;
  logic        sec_dec;
  logic        next_detect;
  logic [15:0] next_fails;
  logic [15:0] next_sleep;
  logic [15:0] status_word;
  logic [15:0] fw_word;
  logic [15:0] read_mux;
  logic [15:0] pct_clamped;
  logic [15:0] min_clamped;
  logic [15:0] fail_sum;
  logic [7:0]  exc_code;

  // function decode
  assign func_read  = (req_func == FUNC_READ);
  assign func_write = (req_func == FUNC_WRITE_ONE) ||
                      (req_func == FUNC_WRITE_MANY);
  assign func_ok    = func_read || func_write;
  assign exc_en     = control[CB_EXC_EN];

  assign addr_ok = (req_addr == ADDR_FAULT)     ||
                   (req_addr == ADDR_FW_LOW)    ||
                   (req_addr == ADDR_BATT_PCT)  ||
                   (req_addr == ADDR_BATT_MIN)  ||
                   (req_addr == ADDR_FW_HIGH)   ||
                   (req_addr == ADDR_SLEEP)     ||
                   (req_addr == ADDR_CONTROL)   ||
                   (req_addr == ADDR_STATUS)    ||
                   (req_addr == ADDR_FAILS)     ||
                   (req_addr == ADDR_UP_SEC_HI) ||
                   (req_addr == ADDR_UP_SEC_LO) ||
                   (req_addr == ADDR_UP_MS);

  // with exceptions off, bad requests still get a plain answer
  assign exc_code = !func_ok ? EXC_BAD_FUNC :
                    !addr_ok ? EXC_BAD_ADDR : EXC_NONE;
  assign give_exc = exc_en && (exc_code != EXC_NONE);

  // only writable registers see strobes; others ignore writes
  assign do_write   = req_valid && func_write && !give_exc;
  assign wr_sleep   = do_write && (req_addr == ADDR_SLEEP);
  assign wr_control = do_write && (req_addr == ADDR_CONTROL);
  assign wr_fails   = do_write && (req_addr == ADDR_FAILS);

  // fault word is a live view of the conditions, not latched
  always_comb begin
    fault_word               = 16'h0000;
    fault_word[FB_CALIB]     = calib_mode;
    fault_word[FB_ZERO]      = zero_fault;
    fault_word[FB_RANGE]     = range_fault;
    fault_word[FB_CLEARING]  = clearing_fault;
    fault_word[FB_SENSOR]    = sensor_fault;
    fault_word[FB_PROCESSOR] = processor_fault;
    fault_word[FB_MEMORY]    = memory_fault;
    fault_word[FB_TEMP]      = temp_fault;
    fault_word[FB_SPAN]      = span_fault;
    fault_word[FB_GLOBAL]    = global_fault;
  end

  always_comb begin
    status_word                = STATUS_FIXED;
    status_word[SB_BATT_FAULT] = batt_fault;
    status_word[SB_BATT_DET]   = batt_detect;
  end

  assign fw_word = {FW_MAJOR, FW_MINOR};

  // battery life limits
  assign pct_clamped = (batt_pct_in > BATT_PCT_MAX) ?
                       BATT_PCT_MAX : batt_pct_in;
  assign min_clamped = (|batt_min_in[31:16]) ?
                       BATT_MIN_MAX : batt_min_in[15:0];

  // battery poll bookkeeping
  assign fail_hit    = batt_poll_done && !batt_poll_ok;
  assign next_detect = batt_detect || (batt_poll_done && batt_poll_ok);
  // counter saturates rather than wrapping back to a small count
  assign fail_sum    = (fail_count > (BATT_FAIL_MAX - BATT_FAIL_STEP)) ?
                       BATT_FAIL_MAX : fail_count + BATT_FAIL_STEP;

  // a failure in the same cycle as a clear is still counted
  assign next_fails = fail_hit ? ((wr_fails && req_wdata == 16'h0000) ?
                                  BATT_FAIL_STEP : fail_sum) :
                      (wr_fails && req_wdata == 16'h0000) ?
                      16'h0000 : fail_count;

  // countdown: a new write takes precedence over the second tick
  assign sec_dec    = tm.sec_tick && (sleep_count != SLEEP_RESET);
  assign next_sleep = wr_sleep ? req_wdata :
                      sec_dec  ? sleep_count - 16'h0001 :
                      sleep_count;

  // read selection
  always_comb begin
    case (req_addr)
      ADDR_FAULT:     read_mux = fault_word;
      ADDR_FW_LOW:    read_mux = fw_word;
      ADDR_BATT_PCT:  read_mux = batt_pct;
      ADDR_BATT_MIN:  read_mux = batt_min;
      ADDR_FW_HIGH:   read_mux = fw_word;
      ADDR_SLEEP:     read_mux = sleep_count;
      ADDR_CONTROL:   read_mux = control;
      ADDR_STATUS:    read_mux = status_word;
      ADDR_FAILS:     read_mux = fail_count;
      ADDR_UP_SEC_HI: read_mux = tm.sec_count[31:16];
      ADDR_UP_SEC_LO: read_mux = tm.sec_count[15:0];
      ADDR_UP_MS:     read_mux = tm.ms_count;
      default:        read_mux = 16'h0000;
    endcase
  end

  // microcontroller reset restarts uptime and the node's own state
  assign tm.clear = soft_rst;

  always_ff @(posedge clk) begin
    if (sys_rst || soft_rst) begin
      batt_detect <= 1'b0;
      batt_fault  <= 1'b0;
      fail_count  <= 16'h0000;
      batt_pct    <= 16'h0000;
      batt_min    <= 16'h0000;
    end else begin
      batt_detect <= next_detect;
      if (batt_poll_done) begin
        batt_fault <= next_detect && !batt_poll_ok;
      end
      if (batt_poll_done && batt_poll_ok) begin
        batt_pct <= pct_clamped;
        batt_min <= min_clamped;
      end
      fail_count <= next_fails;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || soft_rst) begin
      control         <= CONTROL_RESET;
      sleep_count     <= SLEEP_RESET;
      radio_low_power <= 1'b0;
    end else begin
      if (wr_control) begin
        control <= req_wdata & CONTROL_MASK;
      end
      sleep_count     <= next_sleep;
      radio_low_power <= (next_sleep != SLEEP_RESET);
    end
  end

  // reset bits act once and clear with the rest of the control state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      soft_rst          <= 1'b0;
      mcu_reset_pulse   <= 1'b0;
      radio_reset_pulse <= 1'b0;
    end else begin
      soft_rst          <= wr_control && (req_wdata[CB_RST_RADIO] ||
                                          req_wdata[CB_RST_MCU]);
      mcu_reset_pulse   <= wr_control && (req_wdata[CB_RST_RADIO] ||
                                          req_wdata[CB_RST_MCU]);
      radio_reset_pulse <= wr_control && req_wdata[CB_RST_RADIO];
    end
  end

  // every request gets one answer on the next edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_valid     <= 1'b0;
      rsp_data      <= 16'h0000;
      rsp_exception <= 1'b0;
      rsp_exc_code  <= EXC_NONE;
    end else begin
      rsp_valid     <= req_valid;
      if (req_valid) begin
        rsp_exception <= give_exc;
        rsp_exc_code  <= give_exc ? exc_code : EXC_NONE;
        rsp_data      <= give_exc ? 16'h0000 :
                         func_read ? read_mux : req_wdata;
      end
    end
  end

endmodule

// >>> ssr_bank_monitor.sv
/*
 * ssr_bank_monitor: port-level assertions for ssr_bank.
 * Assumes it is bound into ssr_bank and sees only its ports.
 */
`timescale 1ns/100ps
module ssr_bank_monitor
  import ssr_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        req_valid,
  input wire logic [7:0]  req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic        rsp_exception,
  input wire logic [7:0]  rsp_exc_code,
  input wire logic        calib_mode,
  input wire logic        zero_fault,
  input wire logic        range_fault,
  input wire logic        clearing_fault,
  input wire logic        sensor_fault,
  input wire logic        processor_fault,
  input wire logic        memory_fault,
  input wire logic        temp_fault,
  input wire logic        span_fault,
  input wire logic        global_fault,
  input wire logic        radio_low_power,
  input wire logic        mcu_reset_pulse,
  input wire logic        radio_reset_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic [15:0] fault_now = {1'b0, calib_mode, 1'b0, zero_fault,
    range_fault, 1'b0, clearing_fault, 1'b0, sensor_fault, processor_fault,
    memory_fault, 2'b00, temp_fault, span_fault, global_fault};
  wire logic rd_req = req_valid && req_func == FUNC_READ;
  wire logic wr_req = req_valid && (req_func == FUNC_WRITE_ONE ||
    req_func == FUNC_WRITE_MANY);

  property p_taken; req_valid |=> rsp_valid; endproperty
  a_taken: assert property (p_taken) else $error("no answer");
  property p_quiet; !req_valid |=> !rsp_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("stray answer");
  property p_code;
    rsp_valid |-> rsp_exception == (rsp_exc_code != EXC_NONE);
  endproperty
  a_code: assert property (p_code) else $error("bad code");
  property p_fault;
    rd_req && req_addr == ADDR_FAULT |=> rsp_data == $past(fault_now);
  endproperty
  a_fault: assert property (p_fault) else $error("fault");
  property p_status;
    rd_req && req_addr == ADDR_STATUS |=>
      (rsp_data & 16'hFFCF) == STATUS_FIXED && !(rsp_data[5] && !rsp_data[4]);
  endproperty
  a_status: assert property (p_status) else $error("status");
  property p_pct;
    rd_req && req_addr == ADDR_BATT_PCT |=> rsp_data <= BATT_PCT_MAX;
  endproperty
  a_pct: assert property (p_pct) else $error("percent");
  property p_ms; rd_req && req_addr == ADDR_UP_MS |=> rsp_data <= MS_LAST;
  endproperty
  a_ms: assert property (p_ms) else $error("ms range");
  property p_ro;
    wr_req && req_addr == ADDR_FAULT |=>
      !rsp_exception && rsp_data == $past(req_wdata);
  endproperty
  a_ro: assert property (p_ro) else $error("ro write");
  property p_sleep;
    wr_req && req_addr == ADDR_SLEEP |=>
      radio_low_power == ($past(req_wdata) != 16'h0000);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep");
  property p_soft;
    wr_req && req_addr == ADDR_CONTROL &&
      (req_wdata[CB_RST_MCU] || req_wdata[CB_RST_RADIO])
      |=> mcu_reset_pulse ##1 !mcu_reset_pulse;
  endproperty
  a_soft: assert property (p_soft) else $error("reset pulse");
  property p_radio; radio_reset_pulse |-> mcu_reset_pulse; endproperty
  a_radio: assert property (p_radio) else $error("radio reset");
  property p_boot; $fell(sys_rst) |-> !radio_low_power && !rsp_valid;
  endproperty
  a_boot: assert property (p_boot) else $error("boot state");
  c_exc: cover property (rsp_valid && rsp_exception);
  c_wake: cover property ($fell(radio_low_power));
  c_mcu: cover property (mcu_reset_pulse && !radio_reset_pulse);
endmodule

bind ssr_bank ssr_bank_monitor i_mon (.clk(clk), .sys_rst(sys_rst),
  .req_valid(req_valid), .req_func(req_func), .req_addr(req_addr),
  .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .rsp_exception(rsp_exception), .rsp_exc_code(rsp_exc_code),
  .calib_mode(calib_mode), .zero_fault(zero_fault),
  .range_fault(range_fault), .clearing_fault(clearing_fault),
  .sensor_fault(sensor_fault), .processor_fault(processor_fault),
  .memory_fault(memory_fault), .temp_fault(temp_fault),
  .span_fault(span_fault), .global_fault(global_fault),
  .radio_low_power(radio_low_power), .mcu_reset_pulse(mcu_reset_pulse),
  .radio_reset_pulse(radio_reset_pulse));

// >>> ssr_ctl_model.sv
/*
 * ssr_ctl_model: Modbus controller side, one register request at a time.
 * Assumes the bank answers on the taking edge itself, readable just after it.
 */
`timescale 1ns/100ps
module ssr_ctl_model
  import ssr_pkg::*;
(
  input  wire logic        clk,
  output logic             req_valid,
  output logic [7:0]       req_func,
  output logic [15:0]      req_addr,
  output logic [15:0]      req_wdata,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  input  wire logic        rsp_exception,
  input  wire logic [7:0]  rsp_exc_code
);
  initial begin
    req_valid = 1'b0;
    req_func  = 8'h00;
    req_addr  = 16'h0000;
    req_wdata = 16'h0000;
  end
  // released lines show the inverse so a stale value is never trusted
  task automatic xfer(input logic [7:0] f, input logic [15:0] a,
                      input logic [15:0] d, output logic [15:0] r,
                      output logic [7:0] x);
    @(posedge clk);
    req_valid <= 1'b1;
    req_func  <= f;
    req_addr  <= a;
    req_wdata <= d;
    @(posedge clk);
    req_valid <= 1'b0;
    req_func  <= ~f;
    req_addr  <= ~a;
    req_wdata <= ~d;
    #1;
    r = rsp_data;
    // a missing answer shows as a code no request can produce
    x = !rsp_valid ? 8'hFF : rsp_exception ? rsp_exc_code : EXC_NONE;
  endtask
endmodule

// >>> test_sensor_status_register_bank.sv
/*
 * test_sensor_status_register_bank: self-checking bench for ssr_bank.
 * Assumes a shortened millisecond prescaler of ten clocks.
 */
`timescale 1ns/100ps
module test_sensor_status_register_bank;
  import ssr_pkg::*;
  localparam int unsigned TICKS = 10;
  localparam logic [7:0]  MAJ   = 8'h12;
  localparam logic [7:0]  MNR   = 8'h34;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        req_valid, rsp_valid, rsp_exception;
  logic [7:0]  req_func, rsp_exc_code, x;
  logic [15:0] req_addr, req_wdata, rsp_data, r, hi, lo, p;
  logic [9:0]  flt = 10'h000;
  logic        bpd = 1'b0, bok = 1'b0;
  logic [15:0] bpct = 16'h0000;
  logic [31:0] bmin = 32'h0000_0000;
  logic        rlp, mrp, rrp;
  int          err_count = 0, checks_done = 0, cyc = 0, n, i, a, e;
  always #4 clk = ~clk;
  // restarts with the uptime counters, on either kind of reset
  always @(posedge clk) cyc <= (sys_rst || mrp) ? 0 : cyc + 1;
  ssr_bank #(.TICK_CYCLES(TICKS), .FW_MAJOR(MAJ), .FW_MINOR(MNR)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_func(req_func), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_exception(rsp_exception), .rsp_exc_code(rsp_exc_code),
    .calib_mode(flt[9]), .zero_fault(flt[8]), .range_fault(flt[7]),
    .clearing_fault(flt[6]), .sensor_fault(flt[5]),
    .processor_fault(flt[4]), .memory_fault(flt[3]), .temp_fault(flt[2]),
    .span_fault(flt[1]), .global_fault(flt[0]), .batt_poll_done(bpd),
    .batt_poll_ok(bok), .batt_pct_in(bpct), .batt_min_in(bmin),
    .radio_low_power(rlp), .mcu_reset_pulse(mrp), .radio_reset_pulse(rrp));
  ssr_ctl_model i_ctl (.clk(clk), .req_valid(req_valid),
    .req_func(req_func), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_exception(rsp_exception), .rsp_exc_code(rsp_exc_code));
  function automatic logic [15:0] fw(input logic [9:0] f);
    return {1'b0, f[9], 1'b0, f[8], f[7], 1'b0, f[6], 1'b0, f[5:3], 2'b00,
            f[2:0]};
  endfunction
  task automatic end_of_test;
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk16(input logic [15:0] g, input logic [15:0] w);
    checks_done++;
    if (g !== w) begin
      err_count++;
      $display("ERROR %0t word %h expected %h", $time, g, w);
    end
  endtask
  task automatic chkx(input logic [7:0] g, input logic [7:0] w);
    checks_done++;
    if (g !== w) begin
      err_count++;
      $display("ERROR %0t code %h expected %h", $time, g, w);
    end
  endtask
  task automatic rd(input logic [15:0] ad, input logic [15:0] w);
    i_ctl.xfer(FUNC_READ, ad, 16'h0000, r, x);
    chkx(x, EXC_NONE);
    chk16(r, w);
  endtask
  task automatic wr(input logic [15:0] ad, input logic [15:0] d);
    i_ctl.xfer(FUNC_WRITE_ONE, ad, d, r, x);
    chkx(x, EXC_NONE);
  endtask
  task automatic poll(input logic ok, input logic [15:0] pc,
                      input logic [31:0] mn);
    @(posedge clk);
    bpd  <= 1'b1;
    bok  <= ok;
    bpct <= pc;
    bmin <= mn;
    @(posedge clk);
    bpd  <= 1'b0;
  endtask
  // ms since release, read back against the cycle count
  task automatic uptime;
    i_ctl.xfer(FUNC_READ, ADDR_UP_SEC_HI, 16'h0000, hi, x);
    i_ctl.xfer(FUNC_READ, ADDR_UP_SEC_LO, 16'h0000, lo, x);
    i_ctl.xfer(FUNC_READ, ADDR_UP_MS, 16'h0000, r, x);
    a = {hi, lo} * 1000 + r;
    e = cyc / TICKS;
    chk16(16'(a + 3 >= e && a <= e + 3), 16'h0001);
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'h80058960));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ADDR_STATUS, STATUS_FIXED);
    rd(ADDR_CONTROL, CONTROL_RESET);
    rd(ADDR_SLEEP, SLEEP_RESET);
    rd(ADDR_FW_HIGH, {MAJ, MNR});
    rd(ADDR_FW_LOW, {MAJ, MNR});
    for (i = 0; i < 12; i++) begin
      e = (i < 2) ? {10{i[0]}} : $urandom;
      @(posedge clk);
      flt <= 10'(e);
      rd(ADDR_FAULT, fw(10'(e)));
    end
    wr(ADDR_FAULT, 16'hFFFF);
    rd(ADDR_FAULT, fw(flt));
    poll(1'b0, 16'h0000, 32'h0);
    rd(ADDR_STATUS, 16'h0044);
    rd(ADDR_FAILS, 16'h0004);
    poll(1'b1, 16'h0096, 32'h0001_0000);
    rd(ADDR_STATUS, 16'h0054);
    rd(ADDR_BATT_PCT, BATT_PCT_MAX);
    rd(ADDR_BATT_MIN, BATT_MIN_MAX);
    p = 16'($urandom_range(100));
    lo = 16'($urandom);
    poll(1'b1, p, {16'h0000, lo});
    rd(ADDR_BATT_PCT, p);
    rd(ADDR_BATT_MIN, lo);
    poll(1'b0, 16'h0000, 32'h0);
    rd(ADDR_STATUS, 16'h0074);
    rd(ADDR_FAILS, 16'h0008);
    wr(ADDR_FAILS, 16'h0005);
    rd(ADDR_FAILS, 16'h0008);
    wr(ADDR_FAILS, 16'h0000);
    rd(ADDR_FAILS, 16'h0000);
    wr(ADDR_SLEEP, 16'h0002);
    chk16({15'h0, rlp}, 16'h0001);
    rd(ADDR_STATUS, 16'h0074);
    n = 0;
    while (rlp === 1'b1 && n < 30000) begin
      @(posedge clk);
      n++;
    end
    chk16(16'(n > 1000 * TICKS && n < 2001 * TICKS), 16'h0001);
    rd(ADDR_SLEEP, 16'h0000);
    wr(ADDR_SLEEP, 16'hFFFF);
    rd(ADDR_SLEEP, 16'hFFFF);
    wr(ADDR_SLEEP, 16'h0000);
    chk16({15'h0, rlp}, 16'h0000);
    uptime;
    rd(ADDR_CONTROL, CONTROL_RESET);
    rd(16'h2005, 16'h0000);
    wr(ADDR_CONTROL, 16'h0800);
    rd(ADDR_CONTROL, 16'h0800);
    i_ctl.xfer(FUNC_READ, 16'h2005, 16'h0000, r, x);
    chkx(x, EXC_BAD_ADDR);
    i_ctl.xfer(8'h04, ADDR_STATUS, 16'h0000, r, x);
    chkx(x, EXC_BAD_FUNC);
    i_ctl.xfer(FUNC_WRITE_MANY, ADDR_SLEEP, 16'h0003, r, x);
    rd(ADDR_SLEEP, 16'h0003);
    wr(ADDR_CONTROL, 16'h0840);
    chk16({14'h0, mrp, rrp}, 16'h0002);
    rd(ADDR_CONTROL, 16'h0000);
    rd(ADDR_SLEEP, 16'h0000);
    rd(ADDR_UP_SEC_LO, 16'h0000);
    uptime;
    wr(ADDR_CONTROL, 16'h0080);
    chk16({14'h0, mrp, rrp}, 16'h0003);
    rd(ADDR_CONTROL, 16'h0000);
    end_of_test;
  end
endmodule
